// file: rtl/pocs_params.svh
// Purpose: constants for the power-on configuration sequencer
// Assumes: 100 MHz mclk_i
// Notes: times in ns, cycle counts derived from them except POCS_CLEAR_CYC
`ifndef POCS_PARAMS_SVH
`define POCS_PARAMS_SVH
`define POCS_CLK_PERIOD_NS 10
`define POCS_CONFIG_TIME_NS 450000
`define POCS_CONFIG_CYC (`POCS_CONFIG_TIME_NS / `POCS_CLK_PERIOD_NS)
`define POCS_BANK_SETTLE_NS 2000
`define POCS_BANK_SETTLE_CYC ((`POCS_BANK_SETTLE_NS + `POCS_CLK_PERIOD_NS - 1) / `POCS_CLK_PERIOD_NS)
`define POCS_ZERO_HOLD_NS 10000
`define POCS_ZERO_HOLD_CYC ((`POCS_ZERO_HOLD_NS + `POCS_CLK_PERIOD_NS - 1) / `POCS_CLK_PERIOD_NS)
`define POCS_CLEAR_CYC 4
`define POCS_CNT_W 20
`endif

// file: rtl/pocs_pkg.sv
// Purpose: types for the power-on configuration sequencer
// Assumes: nothing
// Notes: core supply levels travel as one struct
package pocs_pkg;
	typedef struct packed {
		logic core_start;
		logic core_sag;
		logic core_zero;
	} pocs_core_s;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_DOWNLOAD,
		ST_BANK_WAIT,
		ST_BANK_SETTLE,
		ST_CLEAR,
		ST_OE_WAIT,
		ST_USER,
		ST_ZERO_WAIT
	} pocs_state_e;
endpackage

// file: rtl/pocs_sequencer.sv
// Purpose: power-up, hot-socket and brown-out sequencing
// Assumes: supply comparators deliver digital levels, 1 = supply above threshold, except core_zero_i where 1 = core at 0 V
// Notes: analog thresholds live outside; this block only orders the release
// Operation
// - Outside user mode any supply below threshold raises cutoff and forces output buffers off
// - Pins stay tri-stated until flash-to-SRAM download has completed
// - Weak pull-ups on for whole download, removed at pin release
// - Download starts when core supply crosses the start threshold
// - Download plus user-mode entry fits within the configuration time
// - User mode waits for all bank supplies, 2 us after last one if configuration time has run out
// - In user mode only core sag is watched; sag resets config, tri-states pins
// - After brown-out, download restarts at start threshold, runs configuration time
// - Low-power variant stops monitoring; recovery needs core at 0 V for 10 us
// - Registers cleared and released before I/O tri-state release
// - Clear-pin option holds registers cleared until clear pin deasserts
// - Output-enable-pin option holds tri-state until enable pin asserts
`timescale 1ns/1ps
`include "pocs_params.svh"
module pocs_sequencer #(
	parameter int NUM_BANKS = 4,
	parameter int CONFIG_CYC = `POCS_CONFIG_CYC,
	parameter int BANK_SETTLE_CYC = `POCS_BANK_SETTLE_CYC,
	parameter int ZERO_HOLD_CYC = `POCS_ZERO_HOLD_CYC,
	parameter int CLEAR_CYC = `POCS_CLEAR_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic core_start_ok_i,
	input wire logic core_sag_ok_i,
	input wire logic core_zero_i,
	input wire logic [NUM_BANKS-1:0] bank_ok_i,
	input wire logic low_power_variant_i,
	input wire logic clear_pin_option_i,
	input wire logic oe_pin_option_i,
	input wire logic global_clear_pin_n_i,
	input wire logic global_output_enable_pin_i,
	input wire logic download_done_i,
	output logic supply_low_cutoff_o,
	output logic io_tristate_o,
	output logic weak_pullup_o,
	output logic download_start_o,
	output logic config_reset_o,
	output logic reg_clear_o,
	output logic user_mode_o,
	output logic monitor_active_o
);
	localparam int SYNC_W = 3 + NUM_BANKS + 2;

	pocs_pkg::pocs_state_e state;
	pocs_pkg::pocs_state_e next_state;
	pocs_pkg::pocs_core_s core;
	logic [NUM_BANKS-1:0] bank_ok;
	logic clear_pin_n;
	logic oe_pin;
	logic [SYNC_W-1:0] sync_q;
	logic [`POCS_CNT_W-1:0] cfg_cnt;
	logic [`POCS_CNT_W-1:0] aux_cnt;
	logic [`POCS_CNT_W-1:0] next_cfg_cnt;
	logic [`POCS_CNT_W-1:0] next_aux_cnt;

	// Pins too are asynchronous: clear and enable pins share the synchroniser
	pocs_sync #(
		.WIDTH(SYNC_W),
		.INIT({1'b0, 1'b0, {NUM_BANKS{1'b0}}, 3'b000})
	) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.async_i({global_output_enable_pin_i, global_clear_pin_n_i, bank_ok_i,
			core_start_ok_i, core_sag_ok_i, core_zero_i}),
		.sync_o(sync_q)
	);
	assign core.core_start = sync_q[2];
	assign core.core_sag = sync_q[1];
	assign core.core_zero = sync_q[0];
	assign bank_ok = sync_q[3 +: NUM_BANKS];
	assign clear_pin_n = sync_q[3 + NUM_BANKS];
	assign oe_pin = sync_q[4 + NUM_BANKS];

	function automatic logic cnt_hit(input logic [`POCS_CNT_W-1:0] cnt, input int lim);
		cnt_hit = (cnt >= lim[`POCS_CNT_W-1:0]);
	endfunction

	wire all_banks = &bank_ok;
	wire any_low = !core.core_start || !all_banks;
	wire in_user = (state == pocs_pkg::ST_USER);
	wire in_oe_wait = (state == pocs_pkg::ST_OE_WAIT);
	// Low-power parts stop watching once user mode is reached
	wire monitoring = !(low_power_variant_i && in_user);
	// In user mode only the core sag comparator counts, banks are ignored
	wire brown_out = (in_user || in_oe_wait) && monitoring && !core.core_sag;
	wire cfg_done = cnt_hit(cfg_cnt, CONFIG_CYC);
	wire clear_hold = clear_pin_option_i && !clear_pin_n;
	wire oe_hold = oe_pin_option_i && !oe_pin;
	wire cutoff_now = monitoring && !in_user && any_low;

	always_comb begin
		next_state = state;
		next_cfg_cnt = cfg_cnt;
		next_aux_cnt = aux_cnt;
		if (state != pocs_pkg::ST_OFF && state != pocs_pkg::ST_ZERO_WAIT && !cfg_done) begin
			next_cfg_cnt = cfg_cnt + `POCS_CNT_W'(1);
		end
		unique case (state)
			pocs_pkg::ST_OFF: begin
				next_cfg_cnt = '0;
				if (core.core_start) begin
					next_state = pocs_pkg::ST_DOWNLOAD;
				end
			end
			pocs_pkg::ST_DOWNLOAD: begin
				if (!core.core_start) begin
					next_state = pocs_pkg::ST_OFF;
				end else if (download_done_i) begin
					next_state = pocs_pkg::ST_BANK_WAIT;
				end
			end
			pocs_pkg::ST_BANK_WAIT: begin
				next_aux_cnt = '0;
				if (!core.core_start) begin
					next_state = pocs_pkg::ST_OFF;
				end else if (all_banks) begin
					next_state = pocs_pkg::ST_BANK_SETTLE;
				end
			end
			pocs_pkg::ST_BANK_SETTLE: begin
				next_aux_cnt = aux_cnt + `POCS_CNT_W'(1);
				if (!core.core_start) begin
					next_state = pocs_pkg::ST_OFF;
				end else if (!all_banks) begin
					next_state = pocs_pkg::ST_BANK_WAIT;
				end else if (!cfg_done || cnt_hit(aux_cnt, BANK_SETTLE_CYC - 1)) begin
					// Early banks ride inside the configuration time
					next_aux_cnt = '0;
					next_state = pocs_pkg::ST_CLEAR;
				end
			end
			pocs_pkg::ST_CLEAR: begin
				next_aux_cnt = aux_cnt + `POCS_CNT_W'(1);
				if (!core.core_start) begin
					next_state = pocs_pkg::ST_OFF;
				end else if (cnt_hit(aux_cnt, CLEAR_CYC - 1)) begin
					next_state = pocs_pkg::ST_OE_WAIT;
				end
			end
			pocs_pkg::ST_OE_WAIT: begin
				if (brown_out) begin
					next_state = pocs_pkg::ST_OFF;
				end else if (!oe_hold) begin
					next_state = pocs_pkg::ST_USER;
				end
			end
			pocs_pkg::ST_USER: begin
				next_aux_cnt = '0;
				if (brown_out) begin
					next_state = pocs_pkg::ST_OFF;
				end else if (low_power_variant_i && !core.core_sag) begin
					next_state = pocs_pkg::ST_ZERO_WAIT;
				end
			end
			pocs_pkg::ST_ZERO_WAIT: begin
				// Function not guaranteed after a sag; pins stay off until a full power cycle
				if (!core.core_zero) begin
					next_aux_cnt = '0;
				end else if (!cnt_hit(aux_cnt, ZERO_HOLD_CYC)) begin
					next_aux_cnt = aux_cnt + `POCS_CNT_W'(1);
				end
				if (cnt_hit(aux_cnt, ZERO_HOLD_CYC) && core.core_start) begin
					next_state = pocs_pkg::ST_DOWNLOAD;
				end
			end
		endcase
		if (next_state == pocs_pkg::ST_OFF) begin
			next_cfg_cnt = '0;
		end
	end

	wire next_dl = (next_state == pocs_pkg::ST_DOWNLOAD);
	wire next_user = (next_state == pocs_pkg::ST_USER);
	wire next_pre_clear = (next_state == pocs_pkg::ST_OFF) || next_dl
		|| (next_state == pocs_pkg::ST_BANK_WAIT) || (next_state == pocs_pkg::ST_BANK_SETTLE)
		|| (next_state == pocs_pkg::ST_ZERO_WAIT);
	wire next_cutoff = (next_state == pocs_pkg::ST_ZERO_WAIT) || (monitoring && any_low && !next_user
		&& !(next_state == pocs_pkg::ST_OE_WAIT));

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state <= pocs_pkg::ST_OFF;
			cfg_cnt <= '0;
			aux_cnt <= '0;
		end else begin
			state <= next_state;
			cfg_cnt <= next_cfg_cnt;
			aux_cnt <= next_aux_cnt;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			supply_low_cutoff_o <= 1'b1;
			io_tristate_o <= 1'b1;
			weak_pullup_o <= 1'b0;
			download_start_o <= 1'b0;
			config_reset_o <= 1'b1;
			reg_clear_o <= 1'b1;
			user_mode_o <= 1'b0;
			monitor_active_o <= 1'b1;
		end else begin
			supply_low_cutoff_o <= next_cutoff || cutoff_now && !next_user;
			io_tristate_o <= !next_user;
			weak_pullup_o <= next_dl || (next_state == pocs_pkg::ST_BANK_WAIT)
				|| (next_state == pocs_pkg::ST_BANK_SETTLE) || (next_state == pocs_pkg::ST_CLEAR)
				|| (next_state == pocs_pkg::ST_OE_WAIT);
			download_start_o <= next_dl && !(state == pocs_pkg::ST_DOWNLOAD);
			config_reset_o <= (next_state == pocs_pkg::ST_OFF) || (next_state == pocs_pkg::ST_ZERO_WAIT);
			// Clear option keeps the clear up through OE_WAIT and user mode while the clear pin is low
			reg_clear_o <= next_pre_clear || (next_state == pocs_pkg::ST_CLEAR)
				|| ((next_user || (next_state == pocs_pkg::ST_OE_WAIT)) && clear_hold);
			user_mode_o <= next_user;
			monitor_active_o <= !(low_power_variant_i && next_user);
		end
	end
endmodule

// file: rtl/pocs_sync.sv
// Purpose: two-flop level synchroniser, parameter width
// Assumes: inputs asynchronous to mclk_i
// Notes: first stage read only by the second
`timescale 1ns/1ps
module pocs_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta <= INIT;
			sync_o <= INIT;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule

// file: verification/pocs_flash_model.sv
// Purpose: flash-to-SRAM download partner
// Assumes: start is a one-cycle pulse
// Notes: done holds until config reset
`timescale 1ns/1ps
module pocs_flash_model #(parameter int DL = 8) (
	input wire logic mclk_i,
	input wire logic start_i,
	input wire logic abort_i,
	output logic done_o = 1'b0
);
	int n = 0;
	always @(posedge mclk_i) begin
		if (abort_i || start_i) begin
			n <= start_i ? DL : 0;
			done_o <= 1'b0;
		end else if (n > 1) begin
			n <= n - 1;
		end else if (n == 1) begin
			n <= 0;
			done_o <= 1'b1;
		end
	end
endmodule

// file: verification/pocs_sequencer_assertions.sv
// Purpose: port-level checks of the power-on sequencer
// Assumes: supply levels pass a 2-flop sync, outputs 3 edges late
// Notes: windows of 5 samples cover the sync latency
`timescale 1ns/1ps
module pocs_chk #(parameter int NUM_BANKS = 4) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic core_sag_ok_i,
	input wire logic [NUM_BANKS-1:0] bank_ok_i,
	input wire logic low_power_variant_i,
	input wire logic clear_pin_option_i,
	input wire logic oe_pin_option_i,
	input wire logic global_clear_pin_n_i,
	input wire logic global_output_enable_pin_i,
	input wire logic supply_low_cutoff_o,
	input wire logic io_tristate_o,
	input wire logic weak_pullup_o,
	input wire logic download_start_o,
	input wire logic config_reset_o,
	input wire logic reg_clear_o,
	input wire logic user_mode_o,
	input wire logic monitor_active_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	sequence s_clr_low; (clear_pin_option_i && !global_clear_pin_n_i)[*5]; endsequence
	sequence s_oe_low; (oe_pin_option_i && !global_output_enable_pin_i)[*5]; endsequence
	property p_cut; (~&bank_ok_i)[*5] ##0 (!user_mode_o && !$past(user_mode_o)) |-> supply_low_cutoff_o; endproperty
	a_cut: assert property (p_cut) else $error("cutoff low with a bank down");
	property p_tri; io_tristate_o == !user_mode_o; endproperty
	a_tri: assert property (p_tri) else $error("pins released outside user mode");
	property p_fell; $fell(io_tristate_o) |-> !weak_pullup_o; endproperty
	a_fell: assert property (p_fell) else $error("pull-up kept after release");
	property p_start; download_start_o |-> weak_pullup_o && !config_reset_o ##1 !download_start_o; endproperty
	a_start: assert property (p_start) else $error("bad download start");
	property p_rel; $rose(user_mode_o) |-> (clear_pin_option_i || !$past(reg_clear_o)) && $past(&bank_ok_i, 3);
	endproperty
	a_rel: assert property (p_rel) else $error("user mode before clear or banks");
	property p_brown; user_mode_o && !low_power_variant_i && !core_sag_ok_i
		|-> ##[1:4] (!user_mode_o && config_reset_o && io_tristate_o); endproperty
	a_brown: assert property (p_brown) else $error("brown-out not acted on");
	property p_lp; low_power_variant_i && user_mode_o |-> !monitor_active_o && !supply_low_cutoff_o; endproperty
	a_lp: assert property (p_lp) else $error("monitor still on in low power");
	property p_clr; s_clr_low ##0 (user_mode_o && $past(user_mode_o)) |-> reg_clear_o; endproperty
	a_clr: assert property (p_clr) else $error("registers not held clear");
	property p_clr_hold; s_clr_low |-> !$fell(reg_clear_o); endproperty
	a_clr_hold: assert property (p_clr_hold) else $error("clear dropped while clear pin low");
	property p_oe; s_oe_low |-> !$rose(user_mode_o); endproperty
	a_oe: assert property (p_oe) else $error("pins released without enable");
endmodule
bind pocs_sequencer pocs_chk #(.NUM_BANKS(NUM_BANKS)) u_chk(.*);

// file: verification/pocs_sequencer_tb.sv
// Purpose: scenario bench for the power-on sequencer
// Assumes: short counts 50/3/5/2
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module pocs_sequencer_tb;
	logic mclk_i = 0, rst_i = 1, core = 0, sag = 0, zero = 1, lp = 0, copt = 0, oopt = 0, clr_n = 0, oe_pin = 0;
	logic [3:0] bank = 0;
	logic done, cut, tris, pull, start, creset, rclr, user, mon;
	int err_count = 0, compares = 0, cyc = 0;
	pocs_sequencer #(.CONFIG_CYC(50), .BANK_SETTLE_CYC(3), .ZERO_HOLD_CYC(5), .CLEAR_CYC(2)) u_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .core_start_ok_i(core), .core_sag_ok_i(sag), .core_zero_i(zero),
		.bank_ok_i(bank), .low_power_variant_i(lp), .clear_pin_option_i(copt), .oe_pin_option_i(oopt),
		.global_clear_pin_n_i(clr_n), .global_output_enable_pin_i(oe_pin), .download_done_i(done),
		.supply_low_cutoff_o(cut), .io_tristate_o(tris), .weak_pullup_o(pull), .download_start_o(start),
		.config_reset_o(creset), .reg_clear_o(rclr), .user_mode_o(user), .monitor_active_o(mon));
	pocs_flash_model u_flash (.mclk_i(mclk_i), .start_i(start), .abort_i(creset), .done_o(done));
	initial forever #5 mclk_i = ~mclk_i;
	task conclude;
		if (err_count == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge mclk_i) if (++cyc == 20000) begin err_count++; conclude; end
	task chk(input logic [3:0] got, input logic [3:0] exp);
		compares++;
		if (got !== exp) begin err_count++; $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end
	endtask
	task w(input int n); repeat (n) @(negedge mclk_i); endtask
	task wait_u(input int lim); for (int i = 0; i < lim && user !== 1'b1; i++) w(1); endtask
	task pw(input logic c, input logic z, input logic [3:0] b); core = c; sag = c; zero = z; bank = b; endtask
	task rst; w(1); rst_i = 1; pw(0, 1, 4'h0); w(2); rst_i = 0; endtask
	task up;
		pw(1, 0, 4'hF);
		w(5);
		chk({pull, tris, cut}, 4'h6);
		wait_u(53);
		chk({user, tris, pull, rclr}, 4'h8);
	endtask
	task t_bank;
		rst; pw(1, 0, 4'h7); w(80);
		chk({user, cut}, 4'h1);
		bank = 4'hF; w(4);
		chk(user, 0);
		wait_u(12);
		chk(user, 1);
	endtask
	task t_brown;
		rst; up; pw(0, 0, 4'hF); w(6);
		chk({user, tris, creset}, 4'h3);
		pw(1, 0, 4'hF); wait_u(60);
		chk(user, 1);
	endtask
	task t_lp;
		rst; lp = 1; up;
		chk({mon, cut}, 4'h0);
		pw(0, 0, 4'hF); w(6);
		chk({user, tris}, 4'h1);
		pw(1, 0, 4'hF); w(30);
		chk(user, 0);
		pw(0, 1, 4'hF); w(3);
		pw(1, 0, 4'hF); w(12);
		chk(user, 0);
		pw(0, 1, 4'hF); w(12);
		pw(1, 0, 4'hF); wait_u(60);
		chk(user, 1);
		lp = 0;
	endtask
	task t_opt;
		rst; copt = 1; oopt = 1; clr_n = 0; oe_pin = 0; pw(1, 0, 4'hF); w(70);
		chk(user, 0);
		oe_pin = 1; wait_u(10); w(2);
		chk({user, rclr}, 4'h3);
		clr_n = 1; w(4);
		chk(rclr, 0);
		copt = 0; oopt = 0;
	endtask
	initial begin
		rst; up; t_bank; t_brown; t_lp; t_opt;
		conclude;
	end
endmodule
